// file: verilog/drive_security_lock_pkg.sv
// constants, register map and mode codes of the drive security lock gate
package drive_security_lock_pkg;

	// security command opcodes
	localparam logic [7:0] OP_SET_PW = 8'hf1;
	localparam logic [7:0] OP_UNLOCK = 8'hf2;
	localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
	localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
	localparam logic [7:0] OP_FREEZE = 8'hf5;
	localparam logic [7:0] OP_DISABLE_PW = 8'hf6;

	// lock modes; boot is the one cycle after reset that reads nonvolatile state
	typedef enum logic [1:0] {
		MODE_LOCKED = 2'b00,
		MODE_UNLOCKED = 2'b01,
		MODE_FROZEN = 2'b10,
		MODE_BOOT = 2'b11
	} mode_t;

	// failed comparisons before unlock and erase unit are refused
	localparam int ATTEMPT_LIMIT = 5;

	// master password revision code
	localparam logic [15:0] REV_SHIPPED = 16'hfffe;
	localparam logic [15:0] REV_MIN = 16'h0001;
	localparam logic [15:0] REV_MAX = 16'hfffe;

	// identify words carried out, and the flag position in the second
	localparam int ID_WORD_REV = 92;
	localparam int ID_WORD_SEC = 128;
	localparam int ID_EXH_BIT = 4;

	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_IDENT = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;

	// status fields
	localparam int ST_MODE = 0;
	localparam int ST_LOCK_EN = 2;
	localparam int ST_MAX_LVL = 3;
	localparam int ST_EXH = 4;
	localparam int ST_MISS = 5;
	localparam int ST_PREP = 8;

	// control fields
	localparam int CTRL_HARD_RST = 0;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: verilog/drive_security_lock_gate.sv
// security lock state machine and command gate with an AXI4-Lite status port
//
// How it works
// (RULE1) opcodes f1 to f6 are security commands
// (RULE2) locked refuses media commands until unlock or erase
// (RULE3) no user password means unlocked at power-on
// (RULE4) freeze lock: frozen until power removed
// (RULE5) high level: master password also unlocks
// (RULE6) maximum level: master unlocks only by erase
// (RULE7) master password never enables the lock
// (RULE8) revision code shown in identify word 92
// (RULE9) shipped revision code is fffe
// (RULE10) user password enables lock for next power-on
// (RULE11) lock enabled: media refused until unlock done
// (RULE12) one mismatch counter for both passwords
// (RULE13) five misses set flag, abort unlock, erase
// (RULE14) power-on or hard reset clear count, flag
// (RULE15) locked aborts media, cache, config, microcode commands; the gate aborts only those with cmd_media set, the rest execute
// (RULE16) locked still executes status and housekeeping commands
// (RULE17) unlocked and frozen execute ordinary commands
// (RULE18) host sets master password before enabling lock
// (RULE19) set password replaces master without enabling lock
// (RULE20) frozen aborts password, erase and unlock commands
// (RULE21) lock state, level, revision kept nonvolatile
`timescale 1ns/1ps

module drive_security_lock_gate
	import drive_security_lock_pkg::*;
#(
	parameter int PW_W = 32,
	parameter int ATTEMPTS = drive_security_lock_pkg::ATTEMPT_LIMIT
)
(
	// clock and power-on reset
	input wire logic clk,
	input wire logic rstn,
	// hard reset pin, asynchronous, active high
	input wire logic hard_rst_pin,
	// host command, one per cycle, same clock
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_media,
	input wire logic cmd_use_master,
	input wire logic cmd_max_level,
	input wire logic [PW_W-1:0] cmd_password,
	input wire logic [15:0] cmd_revision,
	// command verdict, one cycle after the command
	output logic cmd_done,
	output logic cmd_exec,
	output logic cmd_abort,
	output logic erase_all,
	// nonvolatile store, read in the cycle after reset
	input wire logic nv_lock_en_in,
	input wire logic nv_max_lvl_in,
	input wire logic [15:0] nv_rev_in,
	input wire logic [PW_W-1:0] nv_user_pw_in,
	input wire logic [PW_W-1:0] nv_master_pw_in,
	output logic nv_lock_en,
	output logic nv_max_lvl,
	output logic [15:0] nv_rev,
	output logic [PW_W-1:0] nv_user_pw,
	output logic [PW_W-1:0] nv_master_pw,
	// identify words
	output logic [15:0] id_word92,
	output logic [15:0] id_word128,
	// axi4-lite slave
	input wire logic awvalid,
	output logic awready,
	input wire logic [drive_security_lock_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [drive_security_lock_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import drive_security_lock_pkg::*;

	localparam int MW = $clog2(ATTEMPTS + 1);
	localparam logic [MW-1:0] LIM = MW'(ATTEMPTS);

	typedef struct packed {
		mode_t mode;
		logic [MW-1:0] miss;
		logic lock_en;
		logic max_lvl;
		logic [15:0] rev;
		logic [PW_W-1:0] upw;
		logic [PW_W-1:0] mpw;
		logic prep;
		logic [15:0] id128;
		logic done;
		logic exec;
		logic abort;
		logic erase;
		logic [2:0] hsync;
		logic hflt;
		logic awready;
		logic aw_got;
		logic [ADDR_W-1:0] awa;
		logic wready;
		logic w_got;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;
	state_t cur, next;
	logic ctrl_hr;
	logic hr;
	logic sec;
	logic pw_ok;
	logic fail;
	logic ok;
	logic exh;
	logic [MW-1:0] base;
	logic [31:0] st;
	assign exh = cur.id128[ID_EXH_BIT];
	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign cmd_done = cur.done;
	assign cmd_exec = cur.exec;
	assign cmd_abort = cur.abort;
	assign erase_all = cur.erase;
	assign nv_lock_en = cur.lock_en;
	assign nv_max_lvl = cur.max_lvl;
	assign nv_rev = cur.rev;
	assign nv_user_pw = cur.upw;
	assign nv_master_pw = cur.mpw;
	assign id_word92 = cur.rev; // [RULE8]
	assign id_word128 = cur.id128; // [RULE13]
	assign awready = cur.awready;
	assign wready = cur.wready;
	assign bvalid = cur.bvalid;
	assign bresp = cur.bresp;
	assign arready = cur.arready;
	assign rvalid = cur.rvalid;
	assign rdata = cur.rdata;
	assign rresp = cur.rresp;

	////////////////////////////////////////////////////////////////////////////
	// next state: bus slave, hard reset filter, lock machine
	always_comb
	begin
		next = cur;
		ctrl_hr = 1'b0;
		ok = 1'b1;
		fail = 1'b0;
		st = '0;
		next.done = 1'b0;
		next.exec = 1'b0;
		next.abort = 1'b0;
		next.erase = 1'b0;

		// status word from live state
		st[ST_MODE+:2] = cur.mode;
		st[ST_LOCK_EN] = cur.lock_en;
		st[ST_MAX_LVL] = cur.max_lvl;
		st[ST_EXH] = exh;
		st[ST_MISS+:MW] = cur.miss;
		st[ST_PREP] = cur.prep;

		// address and data may arrive in either order
		if (awvalid && cur.awready)
		begin
			next.aw_got = 1'b1;
			next.awa = awaddr;
		end
		if (wvalid && cur.wready)
		begin
			next.w_got = 1'b1;
			next.wd = wdata;
			next.ws = wstrb;
		end
		if (cur.bvalid && bready)
			next.bvalid = 1'b0;
		if (cur.aw_got && cur.w_got && !cur.bvalid)
		begin
			next.aw_got = 1'b0;
			next.w_got = 1'b0;
			next.bvalid = 1'b1;
			next.bresp = RESP_OKAY;
			// status and ident are read only; writes there are ignored
			if (cur.awa == REG_CTRL)
				ctrl_hr = cur.ws[0] && cur.wd[CTRL_HARD_RST];
			else if (cur.awa != REG_STATUS && cur.awa != REG_IDENT)
				next.bresp = RESP_SLVERR;
		end
		next.awready = !next.aw_got && !next.bvalid;
		next.wready = !next.w_got && !next.bvalid;

		// read channel
		if (cur.rvalid && rready)
			next.rvalid = 1'b0;
		if (arvalid && cur.arready)
		begin
			next.rvalid = 1'b1;
			next.rresp = RESP_OKAY;
			next.rdata = '0;
			if (araddr == REG_STATUS)
				next.rdata = st;
			else if (araddr == REG_IDENT)
				next.rdata[15:0] = cur.rev;
			else if (araddr != REG_CTRL)
				next.rresp = RESP_SLVERR;
		end
		next.arready = !next.rvalid;

		// hard reset pin: a level counts once stages two and three agree
		next.hsync = {cur.hsync[1:0], hard_rst_pin};
		if (cur.hsync[2] == cur.hsync[1])
			next.hflt = cur.hsync[2];
		hr = (next.hflt && !cur.hflt) || ctrl_hr;

		// password check for the selected password
		sec = cmd_opcode >= OP_SET_PW && cmd_opcode <= OP_DISABLE_PW; // [RULE1]
		pw_ok = cmd_use_master ? (cmd_password == cur.mpw) : (cmd_password == cur.upw);
		if (hr)
			next.prep = 1'b0; // cleared first: a prepare taken in the same cycle wins

		unique case (cur.mode)
			MODE_BOOT:
			begin
				// nonvolatile state picks the first mode
				next.lock_en = nv_lock_en_in; // [RULE21]
				next.max_lvl = nv_max_lvl_in;
				next.rev = nv_rev_in;
				next.upw = nv_user_pw_in;
				next.mpw = nv_master_pw_in;
				next.mode = nv_lock_en_in ? MODE_LOCKED : MODE_UNLOCKED; // [RULE3] [RULE11]
			end
			MODE_LOCKED, MODE_UNLOCKED, MODE_FROZEN:
			begin
				if (cmd_valid)
				begin
					next.done = 1'b1;
					if (cur.mode == MODE_FROZEN && sec && cmd_opcode != OP_FREEZE)
						ok = 1'b0; // [RULE4] [RULE20]
					else if (cur.mode == MODE_LOCKED && cmd_media)
						ok = 1'b0; // [RULE2] [RULE11] [RULE15]
					else if (cur.mode == MODE_LOCKED && (cmd_opcode == OP_SET_PW ||
						cmd_opcode == OP_FREEZE || cmd_opcode == OP_DISABLE_PW))
						ok = 1'b0; // [RULE2]
					else if (exh && (cmd_opcode == OP_UNLOCK || cmd_opcode == OP_ERASE_UNIT))
						ok = 1'b0; // [RULE13]
					else if (cmd_opcode == OP_SET_PW)
					begin
						if (cmd_use_master)
						begin
							// master changes leave the lock function alone
							next.mpw = cmd_password; // [RULE7] [RULE19]
							if (cmd_revision >= REV_MIN && cmd_revision <= REV_MAX)
								next.rev = cmd_revision; // [RULE8]
						end
						else
						begin
							next.upw = cmd_password;
							next.lock_en = 1'b1; // [RULE10]
							next.max_lvl = cmd_max_level;
						end
					end
					else if (cmd_opcode == OP_UNLOCK)
					begin
						// maximum level: master may only erase, so refuse here
						if (cmd_use_master && cur.max_lvl)
							ok = 1'b0; // [RULE6]
						else if (pw_ok)
							next.mode = MODE_UNLOCKED; // [RULE2] [RULE5]
						else
							fail = 1'b1;
					end
					else if (cmd_opcode == OP_ERASE_UNIT)
					begin
						if (!cur.prep)
							ok = 1'b0;
						else if (pw_ok)
						begin
							next.erase = 1'b1; // [RULE6]
							next.upw = '0;
							next.lock_en = 1'b0;
							next.mode = MODE_UNLOCKED; // [RULE2]
						end
						else
							fail = 1'b1;
					end
					else if (cmd_opcode == OP_FREEZE)
						next.mode = MODE_FROZEN; // [RULE4]
					else if (cmd_opcode == OP_DISABLE_PW)
					begin
						if (cmd_use_master && cur.max_lvl)
							ok = 1'b0;
						else if (pw_ok)
						begin
							next.upw = '0;
							next.lock_en = 1'b0;
						end
						else
							fail = 1'b1;
					end
					// everything else passes: unlocked, frozen, or locked housekeeping
					next.exec = ok && !fail; // [RULE16] [RULE17]
					next.abort = !ok || fail;
					// erase unit is only honoured right after erase prepare
					next.prep = ok && cmd_opcode == OP_ERASE_PREP;
				end
			end
		endcase

		// counter: a miss in the hard reset cycle still counts
		base = hr ? '0 : cur.miss; // [RULE14]
		next.miss = base;
		if (fail && base < LIM)
			next.miss = base + MW'(1); // [RULE12]
		next.id128 = '0;
		next.id128[ID_EXH_BIT] = next.miss >= LIM; // [RULE13]
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; shipped values stand until nonvolatile state is read
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cur <= '0;
			cur.mode <= MODE_BOOT;
			cur.rev <= REV_SHIPPED; // [RULE9]
			cur.awready <= 1'b1;
			cur.wready <= 1'b1;
			cur.arready <= 1'b1;
		end
		else
			cur <= next;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	boot_choice_a: assert property (cur.mode == MODE_BOOT |=> // [RULE3]
		cur.mode == ($past(nv_lock_en_in) ? MODE_LOCKED : MODE_UNLOCKED))
	else $error("wrong mode after boot");
	locked_media_a: assert property (cmd_valid && cur.mode == MODE_LOCKED && cmd_media // [RULE15]
		|=> cmd_done && cmd_abort && !cmd_exec)
	else $error("media command passed while locked");
	locked_house_a: assert property (cmd_valid && cur.mode == MODE_LOCKED // [RULE16]
		&& !cmd_media && !sec |=> cmd_exec)
	else $error("housekeeping command refused while locked");
	open_media_a: assert property (cmd_valid && cmd_media && !sec && // [RULE17]
		(cur.mode == MODE_UNLOCKED || cur.mode == MODE_FROZEN) |=> cmd_exec)
	else $error("ordinary command refused when open");
	frozen_hold_a: assert property (cur.mode == MODE_FROZEN |=> cur.mode == MODE_FROZEN) // [RULE4]
	else $error("left frozen mode");
	frozen_refuse_a: assert property (cmd_valid && cur.mode == MODE_FROZEN && sec && // [RULE20]
		cmd_opcode != OP_FREEZE |=> cmd_abort && !cmd_exec && !erase_all)
	else $error("security command ran while frozen");
	master_nolock_a: assert property (cmd_valid && cur.mode == MODE_UNLOCKED && // [RULE7]
		cmd_opcode == OP_SET_PW && cmd_use_master |=> $stable(cur.lock_en))
	else $error("master password changed lock state");
	user_lock_a: assert property (cmd_valid && cur.mode == MODE_UNLOCKED && // [RULE10]
		cmd_opcode == OP_SET_PW && !cmd_use_master |=> cur.lock_en)
	else $error("user password did not enable lock");
	miss_count_a: assert property (fail && !hr && cur.miss < LIM |=> // [RULE12]
		cur.miss == $past(cur.miss) + MW'(1))
	else $error("mismatch not counted");
	exh_flag_a: assert property (id_word128[ID_EXH_BIT] == (cur.miss >= LIM)) // [RULE13]
	else $error("exhausted flag out of step with count");
	exh_set_a: assert property (fail && !hr && cur.miss == LIM - MW'(1) |=> exh) // [RULE13]
	else $error("exhausted flag not set at limit");
	exh_refuse_a: assert property (exh && cmd_valid && cmd_opcode == OP_UNLOCK // [RULE13]
		&& cur.mode != MODE_BOOT |=> cmd_abort && $stable(cur.mode))
	else $error("unlock ran after attempts exhausted");
	hr_clear_a: assert property (hr && !fail |=> cur.miss == '0 && !exh) // [RULE14]
	else $error("hard reset left count set");
	max_master_a: assert property (cmd_valid && cur.mode == MODE_LOCKED && cur.max_lvl // [RULE6]
		&& cmd_use_master && cmd_opcode == OP_UNLOCK |=> cur.mode == MODE_LOCKED)
	else $error("master unlocked at maximum level");

	erase_cov: cover property (cmd_valid && cmd_opcode == OP_ERASE_UNIT ##1 cur.erase);
	unlock_cov: cover property (cur.mode == MODE_LOCKED ##1 cur.mode == MODE_UNLOCKED);
	exhaust_cov: cover property (!exh ##1 exh);
	freeze_cov: cover property (cur.mode == MODE_UNLOCKED ##1 cur.mode == MODE_FROZEN);

endmodule

// file: test/host_cmd_model.sv
// host controller model that issues one command and collects its verdict
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module host_cmd_model
(
	// clock
	input wire logic clk,
	// command to the gate
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic cmd_media,
	output logic cmd_use_master,
	output logic cmd_max_level,
	output logic [31:0] cmd_password,
	output logic [15:0] cmd_revision,
	// verdict from the gate
	input wire logic cmd_done,
	input wire logic cmd_exec,
	input wire logic cmd_abort,
	input wire logic erase_all
);
	// idle fields start at zero, then hold the inverted opcode, password and revision so stale data never passes for a request
	initial
	begin
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		cmd_media = 1'b0;
		cmd_use_master = 1'b0;
		cmd_max_level = 1'b0;
		cmd_password = 32'h00000000;
		cmd_revision = 16'h0000;
	end

	// one-cycle request, then wait a bounded time for the verdict pulse
	task automatic issue(input int gap, input logic [7:0] op, input logic med, input logic mst,
		input logic mx, input logic [31:0] pw, input logic [15:0] rev, output logic d,
		output logic x, output logic ab, output logic er);
		d = 1'b0;
		x = 1'b0;
		ab = 1'b0;
		er = 1'b0;
		repeat (gap) @(posedge clk);
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		cmd_media <= med;
		cmd_use_master <= mst;
		cmd_max_level <= mx;
		cmd_password <= pw;
		cmd_revision <= rev;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_opcode <= ~op;
		cmd_password <= ~pw;
		cmd_revision <= ~rev;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			if (cmd_done === 1'b1)
			begin
				d = 1'b1;
				x = cmd_exec;
				ab = cmd_abort;
				er = erase_all;
				return;
			end
		end
	endtask
endmodule

// file: test/drive_security_lock_gate_bench.sv
// self-checking bench for the drive security lock gate
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module drive_security_lock_gate_bench;
	import drive_security_lock_pkg::*;
	// arbitrary passwords and two ordinary opcodes, one media and one housekeeping
	localparam logic [31:0] UPW = 32'h1234abcd;
	localparam logic [31:0] MPW = 32'h5a5a0f0f;
	localparam logic [31:0] BAD = 32'h00000bad;
	localparam logic [7:0] OP_MEDIA = 8'h20;
	localparam logic [7:0] OP_PLAIN = 8'h40;
	typedef struct packed {logic [7:0] op; logic mst; logic [31:0] pw; logic ex;} row_t;

	logic clk = 1'b0, rstn = 1'b0, hard_rst_pin = 1'b0;
	logic cmd_valid, cmd_media, cmd_use_master, cmd_max_level, cmd_done, cmd_exec;
	logic cmd_abort, erase_all, nv_lock_en, nv_max_lvl;
	logic [7:0] cmd_opcode;
	logic [31:0] cmd_password, nv_user_pw, nv_master_pw;
	logic [15:0] cmd_revision, id_word92, id_word128, nv_rev;
	logic nv_lock_en_in = 1'b0, nv_max_lvl_in = 1'b0;
	logic [15:0] nv_rev_in = REV_SHIPPED;
	logic [31:0] nv_user_pw_in = UPW, nv_master_pw_in = MPW;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, rd;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, rs;
	logic max_sel = 1'b0;
	int num_errors = 0, n_compared = 0;
	// locked at high level, through unlock and freeze, then the frozen refusals
	row_t rows [16] = '{'{OP_MEDIA, 1'b0, UPW, 1'b0}, '{OP_PLAIN, 1'b0, UPW, 1'b1},
		'{OP_SET_PW, 1'b0, UPW, 1'b0}, '{OP_FREEZE, 1'b0, UPW, 1'b0},
		'{OP_DISABLE_PW, 1'b0, UPW, 1'b0}, '{OP_UNLOCK, 1'b0, BAD, 1'b0},
		'{OP_UNLOCK, 1'b1, MPW, 1'b1}, '{OP_MEDIA, 1'b0, UPW, 1'b1},
		'{OP_FREEZE, 1'b0, UPW, 1'b1}, '{OP_MEDIA, 1'b0, UPW, 1'b1},
		'{OP_SET_PW, 1'b0, UPW, 1'b0}, '{OP_UNLOCK, 1'b0, UPW, 1'b0},
		'{OP_ERASE_PREP, 1'b0, UPW, 1'b0}, '{OP_ERASE_UNIT, 1'b0, UPW, 1'b0},
		'{OP_DISABLE_PW, 1'b0, UPW, 1'b0}, '{OP_FREEZE, 1'b0, UPW, 1'b1}};

	// device under test and host partner
	drive_security_lock_gate #(.PW_W(32), .ATTEMPTS(5)) u_dut (.clk(clk), .rstn(rstn),
		.hard_rst_pin(hard_rst_pin), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_media(cmd_media), .cmd_use_master(cmd_use_master), .cmd_max_level(cmd_max_level),
		.cmd_password(cmd_password), .cmd_revision(cmd_revision), .cmd_done(cmd_done),
		.cmd_exec(cmd_exec), .cmd_abort(cmd_abort), .erase_all(erase_all),
		.nv_lock_en_in(nv_lock_en_in), .nv_max_lvl_in(nv_max_lvl_in), .nv_rev_in(nv_rev_in),
		.nv_user_pw_in(nv_user_pw_in), .nv_master_pw_in(nv_master_pw_in),
		.nv_lock_en(nv_lock_en), .nv_max_lvl(nv_max_lvl), .nv_rev(nv_rev),
		.nv_user_pw(nv_user_pw), .nv_master_pw(nv_master_pw),
		.id_word92(id_word92), .id_word128(id_word128), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	host_cmd_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_media(cmd_media), .cmd_use_master(cmd_use_master), .cmd_max_level(cmd_max_level),
		.cmd_password(cmd_password), .cmd_revision(cmd_revision), .cmd_done(cmd_done),
		.cmd_exec(cmd_exec), .cmd_abort(cmd_abort), .erase_all(erase_all));

	// 50 ns clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic timeout();
		num_errors++;
		$display("CHECK FAILED wait expected answer seen timeout");
		finish_test();
	endtask

	// power cycle with the given nonvolatile lock state and level
	task automatic power_up(input logic lock, input logic maxl);
		nv_lock_en_in <= lock;
		nv_max_lvl_in <= maxl;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	// address and data offered together; each valid drops once its own ready is seen
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (awready === 1'b1)
				aw_p = 1'b0;
			if (wready === 1'b1)
				w_p = 1'b0;
			awvalid <= aw_p;
			wvalid <= w_p;
			if (bvalid === 1'b1)
			begin
				rs = bresp;
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic axi_read(input logic [7:0] a);
		logic ar_p;
		ar_p = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (arready === 1'b1)
				ar_p = 1'b0;
			arvalid <= ar_p;
			if (rvalid === 1'b1)
			begin
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	// housekeeping commands wait three cycles first, the rest go out as soon as the last verdict is seen
	task automatic cmd(input logic [7:0] op, input logic mst, input logic [31:0] pw,
		input logic [15:0] rev, input logic ex, input logic er);
		logic d, x, ab, e;
		u_host.issue(op == OP_PLAIN ? 3 : 0, op, op == OP_MEDIA, mst, max_sel, pw, rev,
			d, x, ab, e);
		chk("cmd_done", 1'b1, d);
		if (d !== 1'b1)
			finish_test();
		chk("cmd_exec", ex, x);
		chk("cmd_abort", !ex, ab);
		chk("erase_all", er, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		power_up(1'b0, 1'b0);
		axi_read(REG_STATUS);
		chk("mode", MODE_UNLOCKED, rd[1:0]);
		chk("id_word92", REV_SHIPPED, id_word92);
		axi_read(REG_IDENT);
		chk("ident", REV_SHIPPED, rd);
		// master first, then user, as a host enabling the lock must do
		cmd(OP_SET_PW, 1'b1, ~MPW, 16'h0002, 1'b1, 1'b0);
		chk("id_word92", 16'h0002, id_word92);
		chk("nv_rev", 16'h0002, nv_rev);
		chk("nv_master_pw", ~MPW, nv_master_pw);
		chk("nv_lock_en", 1'b0, nv_lock_en);
		cmd(OP_SET_PW, 1'b1, MPW, 16'hffff, 1'b1, 1'b0);
		chk("id_word92", 16'h0002, id_word92);
		chk("nv_master_pw", MPW, nv_master_pw);
		max_sel = 1'b1;
		cmd(OP_SET_PW, 1'b0, ~UPW, 16'h0000, 1'b1, 1'b0);
		max_sel = 1'b0;
		chk("nv_lock_en", 1'b1, nv_lock_en);
		chk("nv_user_pw", ~UPW, nv_user_pw);
		chk("nv_max_lvl", 1'b1, nv_max_lvl);
		axi_write(8'h40, 32'h00000000);
		chk("bresp", RESP_SLVERR, rs);
		axi_read(8'h40);
		chk("rresp", RESP_SLVERR, rs);
		axi_write(REG_STATUS, 32'hffffffff);
		chk("bresp", RESP_OKAY, rs);
		$display("test setup done");

		power_up(1'b1, 1'b0);
		axi_read(REG_STATUS);
		chk("mode", MODE_LOCKED, rd[1:0]);
		foreach (rows[i])
			cmd(rows[i].op, rows[i].mst, rows[i].pw, 16'h0003, rows[i].ex, 1'b0);
		axi_read(REG_STATUS);
		chk("mode", MODE_FROZEN, rd[1:0]);
		$display("test table done");

		power_up(1'b1, 1'b0);
		for (int i = 0; i < 5; i++)
			cmd(OP_UNLOCK, 1'b0, BAD, 16'h0000, 1'b0, 1'b0);
		chk("id_word128", 16'h0010, id_word128);
		axi_read(REG_STATUS);
		chk("misses", 3'd5, rd[7:5]);
		cmd(OP_UNLOCK, 1'b0, UPW, 16'h0000, 1'b0, 1'b0);
		cmd(OP_ERASE_UNIT, 1'b1, MPW, 16'h0000, 1'b0, 1'b0);
		hard_rst_pin <= 1'b1;
		for (int i = 0; i < 12 && id_word128 !== 16'h0000; i++)
			@(posedge clk);
		hard_rst_pin <= 1'b0;
		if (id_word128 !== 16'h0000)
			timeout();
		chk("id_word128", 16'h0000, id_word128);
		cmd(OP_UNLOCK, 1'b0, BAD, 16'h0000, 1'b0, 1'b0);
		axi_write(REG_CTRL, 32'h00000001);
		chk("bresp", RESP_OKAY, rs);
		axi_read(REG_STATUS);
		chk("misses", 3'd0, rd[7:5]);
		cmd(OP_UNLOCK, 1'b0, UPW, 16'h0000, 1'b1, 1'b0);
		$display("test attempts done");

		power_up(1'b1, 1'b1);
		cmd(OP_UNLOCK, 1'b1, MPW, 16'h0000, 1'b0, 1'b0);
		cmd(OP_ERASE_UNIT, 1'b1, MPW, 16'h0000, 1'b0, 1'b0);
		cmd(OP_ERASE_PREP, 1'b1, MPW, 16'h0000, 1'b1, 1'b0);
		cmd(OP_ERASE_UNIT, 1'b1, MPW, 16'h0000, 1'b1, 1'b1);
		axi_read(REG_STATUS);
		chk("mode", MODE_UNLOCKED, rd[1:0]);
		chk("max level", 1'b1, rd[ST_MAX_LVL]);
		chk("nv_user_pw", 32'h00000000, nv_user_pw);
		chk("nv_lock_en", 1'b0, nv_lock_en);
		$display("test maximum level done");
		finish_test();
	end
endmodule
